// File: vsw_map.vh
// Purpose: register map and timing constants of the video switch config bank
// Assumes: 8-bit registers, reached by register address and data strobes
// Notes: included by the register bank only; the port selector does not use it
`ifndef VSW_MAP_VH
`define VSW_MAP_VH

`define VSW_ADDR_CFG_A 8'h02
`define VSW_ADDR_CFG_B 8'h03
`define VSW_ADDR_RSV_A 8'h04
`define VSW_ADDR_RSV_B 8'h05
`define VSW_ADDR_RSV_C 8'h06

`define VSW_A_PWR_HI 7
`define VSW_A_PWR_LO 6
`define VSW_A_AUTO 5
`define VSW_A_PRIO_HI 4
`define VSW_A_PRIO_LO 3
`define VSW_A_RSVD 2
`define VSW_A_EDGE_HI 1
`define VSW_A_EDGE_LO 0

`define VSW_B_CDET_DIS 7
`define VSW_B_PSEL_HI 6
`define VSW_B_PSEL_LO 5
`define VSW_B_THR_HI 4
`define VSW_B_THR_LO 3

`define VSW_A_RST 8'h00
`define VSW_B_RST 8'h08
`define VSW_A_WMASK 8'hFB
`define VSW_B_WMASK 8'hF8
`define VSW_RSV_VAL 8'h00

`define VSW_EDGE_FAST 2'h0
`define VSW_EDGE_P50 2'h1
`define VSW_EDGE_P100 2'h2
`define VSW_EDGE_P120 2'h3

`define VSW_THR_RANGE2 2'h0
`define VSW_THR_RANGE3 2'h1
`define VSW_THR_UNDEF 2'h2
`define VSW_THR_RANGE1 2'h3

`define VSW_THR_SEL_R1 3'h1
`define VSW_THR_SEL_R2 3'h2
`define VSW_THR_SEL_R3 3'h4
`define VSW_THR_SEL_RST 3'h4

`define VSW_RD_DFLT 8'h00
`define VSW_PORT_EN_RST 4'h1
`define VSW_PORT_RST 2'h0
`define VSW_EDGE_OH_RST 4'h1
`define VSW_PMODE_RST 2'h0
`define VSW_TERM_RST 1'b0

`endif

// File: vsw_port_pick.v
// Purpose: choose active port from manual field or cable power and priority
// Assumes: power sense already synchronised
// Notes: purely combinational
`timescale 1ns/1ps
module vsw_port_pick (
	input wire auto_en,
	input wire [1:0] prio,
	input wire [1:0] manual_sel,
	input wire [3:0] pwr,
	output reg [1:0] sel
);

	function [1:0] vsw_first;
		input [3:0] p;
		begin
			if (p[0]) vsw_first = 2'h0;
			else if (p[1]) vsw_first = 2'h1;
			else if (p[2]) vsw_first = 2'h2;
			else vsw_first = 2'h3;
		end
	endfunction

	always @* begin
		if (!auto_en) begin
			sel = manual_sel;
		end else if (pwr[prio] || pwr == 4'h0) begin
			sel = prio;
		end else begin
			sel = vsw_first(pwr);
		end
	end

endmodule // vsw_port_pick

// File: vsw_cfg_regs.v
// Purpose: configuration register bank of a four-input video switch
// Assumes: serial slave delivers one-cycle write/read strobes with address
// Notes: read data is registered one cycle after the read strobe
`timescale 1ns/1ps
`include "vsw_map.vh"
module vsw_cfg_regs #(
	parameter DATA_W = 8,
	parameter PORT_N = 4
) (
	input wire clk,
	input wire sys_rst,
	input wire [DATA_W-1:0] reg_addr,
	input wire [DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [PORT_N-1:0] cable_power_sense,
	input wire [PORT_N-1:0] clk_detect,
	output reg [DATA_W-1:0] reg_rdata_r,
	output reg reg_rvalid_r,
	output reg [PORT_N-1:0] port_en_r,
	output reg [1:0] active_port_r,
	output reg clk_term_en_r,
	output reg data_term_en_r,
	output reg [3:0] edge_rate_oh_r,
	output reg [1:0] prio_port_r,
	output reg [2:0] sink_threshold_offset_select_r,
	output reg [1:0] power_mode_r
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// pin levels, only the second stage is read by logic
	reg [PORT_N-1:0] pwr_s1_r;
	reg [PORT_N-1:0] pwr_s2_r;
	reg [PORT_N-1:0] cd_s1_r;
	reg [PORT_N-1:0] cd_s2_r;

	always @(posedge clk) begin
		if (sys_rst) begin
			pwr_s1_r <= {PORT_N{1'b0}};
			pwr_s2_r <= {PORT_N{1'b0}};
			cd_s1_r <= {PORT_N{1'b0}};
			cd_s2_r <= {PORT_N{1'b0}};
		end else begin
			pwr_s1_r <= cable_power_sense;
			pwr_s2_r <= pwr_s1_r;
			cd_s1_r <= clk_detect;
			cd_s2_r <= cd_s1_r;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	reg [DATA_W-1:0] cfg_a_r;
	reg [DATA_W-1:0] cfg_b_r;
	reg [DATA_W-1:0] cfg_a_nxt;
	reg [DATA_W-1:0] cfg_b_nxt;

	// write strobe aimed at one register
	function vsw_hit;
		input wr;
		input [7:0] addr;
		input [7:0] target;
		begin
			vsw_hit = wr && (addr == target);
		end
	endfunction

	wire wr_a = vsw_hit(reg_wr, reg_addr, `VSW_ADDR_CFG_A);
	wire wr_b = vsw_hit(reg_wr, reg_addr, `VSW_ADDR_CFG_B);

	always @* begin
		cfg_a_nxt = cfg_a_r;
		cfg_b_nxt = cfg_b_r;
		// reserved bits forced low, whatever the host sends
		if (wr_a)
			cfg_a_nxt = reg_wdata & `VSW_A_WMASK;
		if (wr_b)
			cfg_b_nxt = reg_wdata & `VSW_B_WMASK;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			cfg_a_r <= `VSW_A_RST;
			cfg_b_r <= `VSW_B_RST;
		end else begin
			cfg_a_r <= cfg_a_nxt;
			cfg_b_r <= cfg_b_nxt;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// unmapped addresses read as zero
	reg [DATA_W-1:0] rdata_nxt;

	always @* begin
		case (reg_addr)
			`VSW_ADDR_CFG_A: rdata_nxt = cfg_a_r;
			`VSW_ADDR_CFG_B: rdata_nxt = cfg_b_r;
			`VSW_ADDR_RSV_A: rdata_nxt = `VSW_RSV_VAL;
			`VSW_ADDR_RSV_B: rdata_nxt = `VSW_RSV_VAL;
			`VSW_ADDR_RSV_C: rdata_nxt = `VSW_RSV_VAL;
			default: rdata_nxt = `VSW_RD_DFLT;
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata_r <= `VSW_RD_DFLT;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_rd;
			if (reg_rd)
				reg_rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	wire [1:0] prio = cfg_a_r[`VSW_A_PRIO_HI:`VSW_A_PRIO_LO];
	wire [1:0] edge_f = cfg_a_r[`VSW_A_EDGE_HI:`VSW_A_EDGE_LO];
	wire [1:0] pmode = cfg_a_r[`VSW_A_PWR_HI:`VSW_A_PWR_LO];
	wire [1:0] psel = cfg_b_r[`VSW_B_PSEL_HI:`VSW_B_PSEL_LO];
	wire [1:0] thr = cfg_b_r[`VSW_B_THR_HI:`VSW_B_THR_LO];
	wire auto_en = cfg_a_r[`VSW_A_AUTO];
	wire cdet_dis = cfg_b_r[`VSW_B_CDET_DIS];
	wire [1:0] sel;

	// ----------------------------------------
	// active port choice
	// ----------------------------------------
	// power sense taken only after the second sync stage
	vsw_port_pick u_pick (
		.auto_en(auto_en),
		.prio(prio),
		.manual_sel(psel),
		.pwr(pwr_s2_r),
		.sel(sel)
	);

	function [3:0] vsw_onehot;
		input [1:0] v;
		begin
			vsw_onehot = 4'h1 << v;
		end
	endfunction

	reg [2:0] thr_dec;

	always @* begin
		case (thr)
			`VSW_THR_RANGE2: thr_dec = `VSW_THR_SEL_R2;
			`VSW_THR_RANGE3: thr_dec = `VSW_THR_SEL_R3;
			`VSW_THR_RANGE1: thr_dec = `VSW_THR_SEL_R1;
			// undefined code selects the reset range
			default: thr_dec = `VSW_THR_SEL_RST;
		endcase
	end

	// ----------------------------------------
	// port enables
	// ----------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			port_en_r <= `VSW_PORT_EN_RST;
			active_port_r <= `VSW_PORT_RST;
		end else begin
			port_en_r <= vsw_onehot(sel);
			active_port_r <= sel;
		end
	end

	// ----------------------------------------
	// input terminations
	// ----------------------------------------
	// clock channel of the selected port terminated from the first clock after reset
	always @(posedge clk) begin
		if (sys_rst) begin
			clk_term_en_r <= `VSW_TERM_RST;
			data_term_en_r <= `VSW_TERM_RST;
		end else begin
			clk_term_en_r <= 1'b1;
			// data lines wait for a seen clock unless detect is off
			data_term_en_r <= cdet_dis | cd_s2_r[sel];
		end
	end

	// ----------------------------------------
	// output slew
	// ----------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			edge_rate_oh_r <= `VSW_EDGE_OH_RST;
		end else begin
			edge_rate_oh_r <= vsw_onehot(edge_f);
		end
	end

	// ----------------------------------------
	// field copies
	// ----------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			prio_port_r <= `VSW_PORT_RST;
			power_mode_r <= `VSW_PMODE_RST;
		end else begin
			prio_port_r <= prio;
			power_mode_r <= pmode;
		end
	end

	// ----------------------------------------
	// sink threshold offset
	// ----------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			sink_threshold_offset_select_r <= `VSW_THR_SEL_RST;
		end else begin
			sink_threshold_offset_select_r <= thr_dec;
		end
	end

endmodule // vsw_cfg_regs

// File: vsw_port_model.sv
// Purpose: connector side, power and clock levels
// Assumes: bench sets the wanted levels
// Notes: one flop of delay
`timescale 1ns/1ps
module vsw_port_model (
	input wire clk,
	input wire [3:0] pwr_req,
	input wire [3:0] clk_req,
	output reg [3:0] cable_power_sense = 4'h0,
	output reg [3:0] clk_detect = 4'h0
);
	always @(posedge clk) begin
		cable_power_sense <= pwr_req;
		clk_detect <= clk_req;
	end
endmodule // vsw_port_model

// File: vsw_cfg_chk_asserts.sv
// Purpose: port checks of the config bank
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module vsw_cfg_chk (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_r,
	input wire reg_rvalid_r,
	input wire [3:0] port_en_r,
	input wire [1:0] active_port_r,
	input wire [3:0] edge_rate_oh_r,
	input wire [1:0] prio_port_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire wa = reg_wr && reg_addr == 8'h02;
	a_rd_ans: assert property (reg_rd |=> reg_rvalid_r)
		else $error("no rvalid");
	a_rd_quiet: assert property (!reg_rd |=> !reg_rvalid_r)
		else $error("stray rvalid");
	a_rsv_zero: assert property (reg_rd && reg_addr[7:2] == 6'h01
		|=> !reg_rdata_r) else $error("rsv data");
	a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata_r))
		else $error("rdata moved");
	a_port_oh: assert property (port_en_r == 4'h1 << active_port_r)
		else $error("port enable");
	a_prio_fol: assert property (wa |-> ##2
		prio_port_r == $past(reg_wdata[4:3], 2)) else $error("prio");
	a_edge_fol: assert property (wa |-> ##2
		edge_rate_oh_r == 4'h1 << $past(reg_wdata[1:0], 2))
		else $error("edge");
	a_edge_oh: assert property ($onehot(edge_rate_oh_r))
		else $error("edge onehot");
	cover property (wa);
	cover property (reg_rd && reg_addr == 8'h05);
	cover property (port_en_r == 4'h8);
endmodule // vsw_cfg_chk
bind vsw_cfg_regs vsw_cfg_chk i_chk (.*);

// File: tb_video_switch_config_regs.sv
// Purpose: bench of the config bank
// Assumes: strobes driven 1 ns after the edge
// Notes: port side by vsw_port_model
`timescale 1ns/1ps
module tb_video_switch_config_regs;
	reg clk = 1'h0;
	reg sys_rst = 1'h1;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'h0;
	reg reg_rd = 1'h0;
	reg [3:0] pwr_req = 4'h0;
	reg [3:0] clk_req = 4'h0;
	reg [7:0] i;
	wire [3:0] cable_power_sense, clk_detect, port_en_r, edge_rate_oh_r;
	wire [7:0] reg_rdata_r;
	wire reg_rvalid_r, clk_term_en_r, data_term_en_r;
	wire [1:0] active_port_r, prio_port_r, power_mode_r;
	wire [2:0] sink_threshold_offset_select_r;
	integer error_cnt = 0;
	integer num_checks = 0;
	always #20 clk = ~clk;
	vsw_cfg_regs i_dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.cable_power_sense(cable_power_sense),
		.clk_detect(clk_detect),
		.reg_rdata_r(reg_rdata_r),
		.reg_rvalid_r(reg_rvalid_r),
		.port_en_r(port_en_r),
		.active_port_r(active_port_r),
		.clk_term_en_r(clk_term_en_r),
		.data_term_en_r(data_term_en_r),
		.edge_rate_oh_r(edge_rate_oh_r),
		.prio_port_r(prio_port_r),
		.sink_threshold_offset_select_r(sink_threshold_offset_select_r),
		.power_mode_r(power_mode_r)
	);
	vsw_port_model i_port (
		.clk(clk),
		.pwr_req(pwr_req),
		.clk_req(clk_req),
		.cable_power_sense(cable_power_sense),
		.clk_detect(clk_detect)
	);
	task tick;
		@(posedge clk);
		#1;
	endtask
	task chk(input [63:0] n, input [7:0] g, input [7:0] e);
		num_checks = num_checks + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("Error %0s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		tick;
		reg_wr = 1'h0;
		repeat (4) tick;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		reg_addr = a;
		reg_rd = 1'h1;
		tick;
		reg_rd = 1'h0;
		chk("rvalid", {7'h00, reg_rvalid_r}, 8'h01);
		chk("rdata", reg_rdata_r, e);
		tick;
		chk("rvalid", {7'h00, reg_rvalid_r}, 8'h00);
	endtask
	task term(input [7:0] e);
		repeat (5) tick;
		chk("term", {7'h00, data_term_en_r}, e);
	endtask
	task t_reset;
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h08);
		chk("thr", {5'h00, sink_threshold_offset_select_r}, 8'h04);
		chk("port", {4'h0, port_en_r}, 8'h01);
		$display("t_reset done");
	endtask
	task t_cfg;
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'h02, i * 8'h09);
			rd(8'h02, i * 8'h09);
			chk("edge", {4'h0, edge_rate_oh_r}, 8'h01 << i);
			chk("prio", {6'h00, prio_port_r}, i);
			wr(8'h03, i * 8'h28);
			rd(8'h03, i * 8'h28);
			chk("port", {4'h0, port_en_r}, 8'h01 << i);
			chk("thr", {5'h00, sink_threshold_offset_select_r},
				i == 0 ? 8'h02 : i == 3 ? 8'h01 : 8'h04);
		end
		$display("t_cfg done");
	endtask
	task t_rsv;
		wr(8'h04, 8'hA5);
		for (i = 4; i < 8; i = i + 1)
			rd(i, 8'h00);
		rd(8'h02, 8'h1B);
		$display("t_rsv done");
	endtask
	task t_term;
		clk_req = 4'h7;
		term(8'h00);
		clk_req = 4'h8;
		term(8'h01);
		clk_req = 4'h0;
		wr(8'h03, 8'hE0);
		term(8'h01);
		wr(8'h03, 8'h60);
		term(8'h00);
		$display("t_term done");
	endtask
	task t_auto;
		wr(8'h02, 8'h30);
		pwr_req = 4'h6;
		repeat (5) tick;
		chk("active", {6'h00, active_port_r}, 8'h02);
		pwr_req = 4'h2;
		repeat (5) tick;
		chk("active", {6'h00, active_port_r}, 8'h01);
		$display("t_auto done");
	endtask
	task t_rst;
		wr(8'h02, 8'hC0);
		chk("pmode", {6'h00, power_mode_r}, 8'h03);
		chk("clkterm", {7'h00, clk_term_en_r}, 8'h01);
		sys_rst = 1'h1;
		repeat (2) tick;
		sys_rst = 1'h0;
		chk("pmode", {6'h00, power_mode_r}, 8'h00);
		chk("port", {4'h0, port_en_r}, 8'h01);
		chk("edge", {4'h0, edge_rate_oh_r}, 8'h01);
		chk("thr", {5'h00, sink_threshold_offset_select_r}, 8'h04);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h08);
		$display("t_rst done");
	endtask
	task close_out;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) tick;
		sys_rst = 1'h0;
		t_reset;
		t_cfg;
		t_rsv;
		t_term;
		t_auto;
		t_rst;
		close_out;
	end
	initial begin
		#100000;
		error_cnt = error_cnt + 1;
		close_out;
	end
endmodule // tb_video_switch_config_regs
